/* rtl/pss_sequencer.sv */
// Program sequencer: fetch address counter, interrupt vectoring,
// return stack and lookup-table reads from the program store.
// Assumes a combinational program store: rom_data answers rom_addr
// within the same cycle. Decoder holds commands while busy is high.
module pss_sequencer
  import pss_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  // Instruction decoder
  input  wire pss_cmd_s             cmd,
  input  wire logic [NUM_IRQ-1:0]   interrupt_enable_flags,
  input  wire logic [NUM_IRQ-1:0]   event_clear,
  input  wire logic [PORTC_W-1:0]   port_c_input_mode,
  // Interrupt sources
  input  wire pss_src_s             src_events,
  input  wire logic [PORTC_W-1:0]   port_c_pins,
  input  wire logic                 ext_int_n,
  // Program store
  output pss_addr_t                 rom_addr,
  input  wire logic [WORD_W-1:0]    rom_data,
  // Status towards the decoder
  output pss_addr_t                 fetch_address_counter,
  output logic                      busy,
  output logic                      irq_taken,
  output logic      [IDX_W-1:0]     irq_index,
  output logic      [NUM_IRQ-1:0]   event_flags,
  output logic      [DEPTH_W-1:0]   stack_depth,
  // Table data towards data RAM
  output logic                      table_valid,
  output logic      [NIB_W-1:0]     table_data,
  output logic      [RAM_AW-1:0]    table_ram_addr
);

  // ----------------------------------------------------------------
  // Pin synchronisers and falling-edge detect
  // ----------------------------------------------------------------
  logic [PORTC_W-1:0] pc_meta, pc_sync, pc_prev;
  logic               ext_meta, ext_sync, ext_prev;
  logic [PORTC_W-1:0] pc_fall;
  logic               ext_fall;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pc_meta  <= 4'hf;
      pc_sync  <= 4'hf;
      pc_prev  <= 4'hf;
      ext_meta <= 1'b1;
      ext_sync <= 1'b1;
      ext_prev <= 1'b1;
    end else begin
      pc_meta  <= port_c_pins;
      pc_sync  <= pc_meta;
      pc_prev  <= pc_sync;
      ext_meta <= ext_int_n;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // Each input-mode pin can raise the port C request on its own
  assign pc_fall  = pc_prev & ~pc_sync & port_c_input_mode;
  assign ext_fall = ext_prev & ~ext_sync;

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  logic [NUM_IRQ-1:0] evt_set;
  logic [NUM_IRQ-1:0] ack_clear;
  logic [NUM_IRQ-1:0] next_event_flags;

  always_comb begin
    evt_set            = '0;
    evt_set[IRQ_DIV]   = src_events.div_ovf;
    evt_set[IRQ_T0]    = src_events.t0_under;
    evt_set[IRQ_PORTC] = |pc_fall;
    evt_set[IRQ_EXT]   = ext_fall;
    evt_set[IRQ_SIN]   = src_events.sin_done;
    evt_set[IRQ_SOUT]  = src_events.sout_done;
    evt_set[IRQ_T1]    = src_events.t1_under;
    // A new event in the clearing cycle survives the clear
    next_event_flags = (event_flags & ~event_clear & ~ack_clear) | evt_set;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n)
      event_flags <= '0;
    else
      event_flags <= next_event_flags;
  end

  // ----------------------------------------------------------------
  // Arbiter and return stack
  // ----------------------------------------------------------------
  logic             irq_any;
  logic [IDX_W-1:0] irq_sel;
  pss_addr_t        stack_top;
  logic             push, pop;
  pss_addr_t        push_data;

  pss_irq_arbiter u_arb (
    .flags   (event_flags),
    .enables (interrupt_enable_flags),
    .any     (irq_any),
    .index   (irq_sel)
  );

  pss_return_stack u_stack (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .push      (push),
    .pop       (pop),
    .push_data (push_data),
    .top       (stack_top),
    .depth     (stack_depth)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  pss_state_e        state, next_state;
  pss_addr_t         next_fac, next_rom_addr;
  logic              next_busy, next_irq_taken, next_table_valid;
  logic [IDX_W-1:0]  next_irq_index;
  logic [NIB_W-1:0]  next_table_data;
  logic [RAM_AW-1:0] next_table_ram_addr;
  logic [1:0]        nib_sel, next_nib_sel;
  logic              take_cmd, take_irq;

  assign take_cmd = (state == PSS_ST_RUN) && cmd.valid;
  // Interrupts only between instructions, so the decoder sees a clean boundary
  assign take_irq = (state == PSS_ST_RUN) && !cmd.valid && irq_any;

  always_comb begin
    next_state          = state;
    next_fac            = fetch_address_counter;
    next_rom_addr       = rom_addr;
    next_irq_taken      = 1'b0;
    next_irq_index      = irq_index;
    next_table_valid    = 1'b0;
    next_table_data     = table_data;
    next_table_ram_addr = table_ram_addr;
    next_nib_sel        = nib_sel;
    push                = 1'b0;
    pop                 = 1'b0;
    push_data           = fetch_address_counter;
    ack_clear           = '0;
    case (state)
      PSS_ST_RUN: begin
        if (take_cmd) begin
          case (cmd.op)
            PSS_OP_STEP: begin
              next_fac = fetch_address_counter + ADDR_ONE;
            end
            PSS_OP_JUMP: begin
              next_fac = cmd.target;
            end
            PSS_OP_CALL: begin
              push      = 1'b1;
              push_data = fetch_address_counter + ADDR_ONE;
              next_fac  = cmd.target;
            end
            PSS_OP_RET: begin
              pop      = 1'b1;
              next_fac = stack_top;
            end
            PSS_OP_TABLE: begin
              next_fac            = fetch_address_counter + ADDR_ONE;
              next_state          = PSS_ST_TABLE;
              next_nib_sel        = cmd.table_index[1:0];
              next_table_ram_addr = cmd.ram_addr;
            end
            default: begin
              next_fac = fetch_address_counter + ADDR_ONE;
            end
          endcase
        end else if (take_irq) begin
          push               = 1'b1;
          next_fac           = IRQ_VEC[irq_sel];
          next_irq_taken     = 1'b1;
          next_irq_index     = irq_sel;
          ack_clear[irq_sel] = 1'b1;
        end
        // Table words sit only in the top quarter of the store
        if (take_cmd && cmd.op == PSS_OP_TABLE)
          next_rom_addr = pss_table_word(cmd.table_index);
        else
          next_rom_addr = next_fac;
      end
      PSS_ST_TABLE: begin
        next_table_data  = pss_table_nib(rom_data, nib_sel);
        next_table_valid = 1'b1;
        next_rom_addr    = fetch_address_counter;
        next_state       = PSS_ST_RUN;
      end
      default: begin
        next_state = PSS_ST_RUN;
      end
    endcase
    next_busy = (next_state == PSS_ST_TABLE);
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state                 <= PSS_ST_RUN;
      fetch_address_counter <= RESET_VEC;
      rom_addr              <= RESET_VEC;
      busy                  <= 1'b0;
      irq_taken             <= 1'b0;
      irq_index             <= IRQ_DIV;
      table_valid           <= 1'b0;
      table_data            <= '0;
      table_ram_addr        <= '0;
      nib_sel               <= 2'h0;
    end else begin
      state                 <= next_state;
      fetch_address_counter <= next_fac;
      rom_addr              <= next_rom_addr;
      busy                  <= next_busy;
      irq_taken             <= next_irq_taken;
      irq_index             <= next_irq_index;
      table_valid           <= next_table_valid;
      table_data            <= next_table_data;
      table_ram_addr        <= next_table_ram_addr;
      nib_sel               <= next_nib_sel;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  logic [NUM_IRQ-1:0] armed_now;
  assign armed_now = event_flags & interrupt_enable_flags;

  chk_step_advance: assert property (
    take_cmd && cmd.op == PSS_OP_STEP |=>
      fetch_address_counter == $past(fetch_address_counter) + ADDR_ONE)
    else $error("counter did not advance by one");

  chk_jump_load: assert property (
    take_cmd && (cmd.op == PSS_OP_JUMP || cmd.op == PSS_OP_CALL) |=>
      fetch_address_counter == $past(cmd.target) && rom_addr == $past(cmd.target))
    else $error("jump or call target not loaded");

  chk_reset_start: assert property (disable iff (1'b0)
    !reset_n |=> fetch_address_counter == RESET_VEC && rom_addr == RESET_VEC && !busy)
    else $error("reset did not start at zero");

  chk_irq_vector: assert property (
    irq_taken |-> fetch_address_counter == IRQ_VEC[irq_index])
    else $error("interrupt vector wrong");

  chk_irq_priority: assert property (
    take_irq |=> irq_taken &&
      (($past(armed_now) & ((7'h01 << irq_index) - 7'h01)) == 7'h00))
    else $error("lower priority interrupt taken first");

  chk_irq_enable: assert property (
    irq_taken |-> $past(armed_now[irq_sel]) && $past(irq_sel) == irq_index)
    else $error("interrupt taken without flag and enable");

  chk_call_push: assert property (
    take_cmd && cmd.op == PSS_OP_CALL |=>
      stack_depth == (($past(stack_depth) == 4'h8) ? 4'h8 : $past(stack_depth) + 4'h1))
    else $error("call did not push the stack");

  chk_ret_pop: assert property (
    take_cmd && cmd.op == PSS_OP_RET |=> fetch_address_counter == $past(stack_top))
    else $error("return did not pop the stack");

  chk_call_return: assert property (
    take_cmd && cmd.op == PSS_OP_CALL ##1 take_cmd && cmd.op == PSS_OP_RET |=>
      fetch_address_counter == $past(fetch_address_counter, 2) + ADDR_ONE)
    else $error("immediate return lost the call address");

  chk_stack_cap: assert property (
    stack_depth <= 4'h8)
    else $error("stack deeper than eight");

  chk_table_area: assert property (
    state == PSS_ST_TABLE |-> rom_addr > INSTR_ONLY_TOP)
    else $error("table read outside table area");

  chk_table_beat: assert property (
    take_cmd && cmd.op == PSS_OP_TABLE |=> busy ##1 table_valid && !busy &&
      table_data == pss_table_nib($past(rom_data), $past(nib_sel)))
    else $error("table element not delivered");

  chk_portc_flag: assert property (
    |pc_fall |=> event_flags[IRQ_PORTC])
    else $error("port C edge lost");

  chk_irq_ack_clear: assert property (
    take_irq && !evt_set[irq_sel] |=> !event_flags[irq_index])
    else $error("accepted event flag not cleared");

  chk_irq_return: assert property (
    take_irq ##1 take_cmd && cmd.op == PSS_OP_RET |=>
      fetch_address_counter == $past(fetch_address_counter, 2))
    else $error("return after interrupt lost the address");

endmodule

/* rtl/pss_pkg.sv */
// Constants, types and helpers shared by the program sequencer files.
// Assumes one 20 MHz clock (mclk) and a synchronous active-low reset.
//
// Summary of operation
// - 11-bit fetch address counter, 2048x16 store
// - Jump, call, interrupt, reset load target address
// - Reset to 000H; fixed vectors per interrupt
// - Fixed priority: divider first, timer 1 last
// - Eight-entry, 11-bit last-in first-out stack
// - Call pushes the counter plus one, interrupt the counter, automatically
// - Return instruction pops stack into the counter
// - Ninth push overwrites oldest; depth stays eight
// - Table words only in 600H to 7FFH
// - Table read fetches one 4-bit element
// - Each port C input pin interrupts independently
// - Interrupt needs event flag and enable flag
package pss_pkg;

  localparam int ADDR_W      = 11;
  localparam int WORD_W      = 16;
  localparam int NIB_W       = 4;
  localparam int NUM_IRQ     = 7;
  localparam int IDX_W       = 3;
  localparam int STACK_DEPTH = 8;
  localparam int PTR_W       = 3;
  localparam int DEPTH_W     = 4;
  localparam int RAM_AW      = 7;
  localparam int PORTC_W     = 4;

  typedef logic [ADDR_W-1:0] pss_addr_t;

  localparam pss_addr_t RESET_VEC      = 11'h000;
  localparam pss_addr_t ADDR_ONE       = 11'h001;
  localparam pss_addr_t INSTR_ONLY_TOP = 11'h5ff;
  localparam pss_addr_t TABLE_BASE     = 11'h600;

  // Interrupt source indices, in priority order
  localparam logic [IDX_W-1:0] IRQ_DIV   = 3'h0;
  localparam logic [IDX_W-1:0] IRQ_T0    = 3'h1;
  localparam logic [IDX_W-1:0] IRQ_PORTC = 3'h2;
  localparam logic [IDX_W-1:0] IRQ_EXT   = 3'h3;
  localparam logic [IDX_W-1:0] IRQ_SIN   = 3'h4;
  localparam logic [IDX_W-1:0] IRQ_SOUT  = 3'h5;
  localparam logic [IDX_W-1:0] IRQ_T1    = 3'h6;

  localparam pss_addr_t IRQ_VEC [NUM_IRQ] = '{11'h004, 11'h008, 11'h00c, 11'h014,
                                             11'h018, 11'h01c, 11'h020};

  typedef enum logic [2:0] {
    PSS_OP_STEP,
    PSS_OP_JUMP,
    PSS_OP_CALL,
    PSS_OP_RET,
    PSS_OP_TABLE
  } pss_op_e;

  typedef enum logic {
    PSS_ST_RUN,
    PSS_ST_TABLE
  } pss_state_e;

  // One instruction from the decoder, valid for one cycle
  typedef struct packed {
    logic              valid;
    pss_op_e           op;
    pss_addr_t         target;
    pss_addr_t         table_index;
    logic [RAM_AW-1:0] ram_addr;
  } pss_cmd_s;

  // Event pulses from on-chip sources (same clock)
  typedef struct packed {
    logic div_ovf;
    logic t0_under;
    logic sin_done;
    logic sout_done;
    logic t1_under;
  } pss_src_s;

  // Element i lives in word 600H + i/4, nibble i%4 (low nibble first)
  function automatic pss_addr_t pss_table_word(input pss_addr_t idx);
    pss_table_word = TABLE_BASE + {2'h0, idx[ADDR_W-1:2]};
  endfunction

  function automatic logic [NIB_W-1:0] pss_table_nib(input logic [WORD_W-1:0] w,
                                                     input logic [1:0] sel);
    pss_table_nib = w[sel*NIB_W +: NIB_W];
  endfunction

endpackage

/* rtl/pss_return_stack.sv */
// Eight-level circular return stack for the program sequencer.
// Assumes push and pop are never asserted in the same cycle.
module pss_return_stack
  import pss_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               reset_n,
  // Stack control
  input  wire logic               push,
  input  wire logic               pop,
  input  wire pss_addr_t          push_data,
  // Stack state
  output pss_addr_t               top,
  output logic      [DEPTH_W-1:0] depth
);

  pss_addr_t              mem [STACK_DEPTH];
  logic      [PTR_W-1:0]  ptr;
  logic      [PTR_W-1:0]  next_ptr;
  logic      [DEPTH_W-1:0] next_depth;

  // Circular pointer: a ninth push lands on the oldest entry
  always_comb begin
    next_ptr   = ptr;
    next_depth = depth;
    if (push) begin
      next_ptr = ptr + 3'h1;
      if (depth != DEPTH_W'(STACK_DEPTH))
        next_depth = depth + 4'h1;
    end else if (pop) begin
      next_ptr = ptr - 3'h1;
      if (depth != 4'h0)
        next_depth = depth - 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ptr   <= 3'h0;
      depth <= 4'h0;
    end else begin
      ptr   <= next_ptr;
      depth <= next_depth;
    end
  end

  // Storage is not reset; only the pointer defines content
  always_ff @(posedge mclk) begin
    if (push)
      mem[ptr] <= push_data;
  end

  assign top = mem[ptr - 3'h1];

endmodule

/* rtl/pss_irq_arbiter.sv */
// Fixed-priority selection among the seven interrupt sources.
// Purely combinational; the caller registers the result.
module pss_irq_arbiter
  import pss_pkg::*;
(
  // Flags and enables
  input  wire logic [NUM_IRQ-1:0] flags,
  input  wire logic [NUM_IRQ-1:0] enables,
  // Selection
  output logic                    any,
  output logic      [IDX_W-1:0]   index
);

  function automatic logic [IDX_W-1:0] first_set(input logic [NUM_IRQ-1:0] v);
    first_set = IRQ_DIV;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (v[i])
        first_set = IDX_W'(i);
    end
  endfunction

  logic [NUM_IRQ-1:0] armed;

  assign armed = flags & enables;
  assign any   = |armed;
  assign index = first_set(armed);

endmodule

/* test/pss_rom_model.sv */
// Behavioural program store facing the sequencer's fetch port.
// Assumes a combinational read, answering rom_addr in the same cycle.
module pss_rom_model
  import pss_pkg::*;
(
  // Program store port
  input  wire pss_addr_t         rom_addr,
  output logic      [WORD_W-1:0] rom_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // Store contents
  // ----------------------------------------
  // Address-dependent pattern, so a wrong word or nibble shows up
  always_comb begin
    rom_data = {rom_addr, rom_addr[4:0]} ^ 16'h9c35;
  end
endmodule

/* test/program_sequencer_stack_tb_top.sv */
// Self-checking bench for the program sequencer and its return stack.
// Assumes the store model beside it; stimulus changes at falling edges, but cmd.valid and the src_events pulses from fire drop at rising edges.
module program_sequencer_stack_tb_top;
  import pss_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 mclk;
  logic                 reset_n;
  pss_cmd_s             cmd;
  logic [NUM_IRQ-1:0]   interrupt_enable_flags;
  logic [NUM_IRQ-1:0]   event_clear;
  logic [PORTC_W-1:0]   port_c_input_mode;
  pss_src_s             src_events;
  logic [PORTC_W-1:0]   port_c_pins;
  logic                 ext_int_n;
  pss_addr_t            rom_addr;
  logic [WORD_W-1:0]    rom_data;
  pss_addr_t            fetch_address_counter;
  logic                 busy;
  logic                 irq_taken;
  logic [IDX_W-1:0]     irq_index;
  logic [NUM_IRQ-1:0]   event_flags;
  logic [DEPTH_W-1:0]   stack_depth;
  logic                 table_valid;
  logic [NIB_W-1:0]     table_data;
  logic [RAM_AW-1:0]    table_ram_addr;
  int                   failures;
  int                   total_checks;

  pss_sequencer i_dut (.mclk, .reset_n, .cmd, .interrupt_enable_flags, .event_clear, .port_c_input_mode,
    .src_events, .port_c_pins, .ext_int_n, .rom_addr, .rom_data, .fetch_address_counter, .busy,
    .irq_taken, .irq_index, .event_flags, .stack_depth, .table_valid, .table_data, .table_ram_addr);

  pss_rom_model i_rom (.rom_addr, .rom_data);

  always #25 mclk = ~mclk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Valid drops by NBA at the taking edge so back-to-back calls never collide
  task automatic do_cmd(input pss_op_e op, input pss_addr_t tgt, input pss_addr_t idx, input logic [6:0] ram);
    cmd = '{valid: 1'b1, op: op, target: tgt, table_index: idx, ram_addr: ram};
    @(posedge mclk);
    cmd.valid <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic fire(input int k, input int pin);
    case (k)
      0: src_events.div_ovf = 1'b1;
      1: src_events.t0_under = 1'b1;
      2: port_c_pins[pin] = 1'b0;
      3: ext_int_n = 1'b0;
      4: src_events.sin_done = 1'b1;
      5: src_events.sout_done = 1'b1;
      default: src_events.t1_under = 1'b1;
    endcase
    @(posedge mclk);
    src_events <= '0;
    @(negedge mclk);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq_taken !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > 20) begin
        failures++;
        $display("ERROR %0t: interrupt never taken", $time);
        end_of_test();
      end
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic flow_basic;
    do_cmd(PSS_OP_JUMP, 11'h123, '0, '0);
    chk(fetch_address_counter, 11'h123);
    chk(rom_addr, 11'h123);
    do_cmd(PSS_OP_STEP, '0, '0, '0);
    chk(fetch_address_counter, 11'h124);
    do_cmd(PSS_OP_CALL, 11'h456, '0, '0);
    chk(fetch_address_counter, 11'h456);
    chk(stack_depth, 4'h1);
    do_cmd(PSS_OP_RET, '0, '0, '0);
    chk(fetch_address_counter, 11'h125);
    chk(stack_depth, 4'h0);
    do_cmd(PSS_OP_JUMP, 11'h7ff, '0, '0);
    do_cmd(PSS_OP_STEP, '0, '0, '0);
    chk(fetch_address_counter, 11'h000);
  endtask

  // Nine calls: the first return address must be the one lost
  task automatic stack_overflow;
    do_cmd(PSS_OP_JUMP, 11'h100, '0, '0);
    for (int i = 0; i < 9; i++) do_cmd(PSS_OP_CALL, 11'h200 + i[10:0], '0, '0);
    chk(stack_depth, 4'h8);
    for (int j = 0; j < 8; j++) begin
      do_cmd(PSS_OP_RET, '0, '0, '0);
      chk(fetch_address_counter, 11'h208 - j[10:0]);
    end
    chk(stack_depth, 4'h0);
  endtask

  task automatic table_rd(input pss_addr_t idx, input logic [6:0] ram);
    pss_addr_t   a;
    pss_addr_t   pc_old;
    logic [15:0] w;
    pc_old = fetch_address_counter;
    a = 11'h600 + (idx >> 2);
    w = {a, a[4:0]} ^ 16'h9c35;
    do_cmd(PSS_OP_TABLE, '0, idx, ram);
    chk(busy, 1'b1);
    chk(rom_addr, a);
    @(negedge mclk);
    chk(table_valid, 1'b1);
    chk(table_data, w[idx[1:0]*4 +: 4]);
    chk(table_ram_addr, ram);
    chk(busy, 1'b0);
    chk(fetch_address_counter, pc_old + 11'h001);
    @(negedge mclk);
    chk(table_valid, 1'b0);
  endtask

  task automatic irq_one(input int k, input int pin);
    pss_addr_t ret_to;
    ret_to = fetch_address_counter;
    fire(k, pin);
    repeat (6) begin
      @(negedge mclk);
      chk(irq_taken, 1'b0);
    end
    chk(event_flags[k], 1'b1);
    interrupt_enable_flags[k] = 1'b1;
    wait_irq();
    chk(irq_index, k[2:0]);
    chk(fetch_address_counter, IRQ_VEC[k]);
    chk(stack_depth, 4'h1);
    interrupt_enable_flags = '0;
    do_cmd(PSS_OP_RET, '0, '0, '0);
    chk(fetch_address_counter, ret_to);
    port_c_pins = 4'hf;
    ext_int_n = 1'b1;
    // Let the pins settle before the next scenario touches them
    @(negedge mclk);
  endtask

  // Software clear, set beating clear, and an output-mode pin that stays quiet
  task automatic flag_clear;
    fire(1, 0);
    event_clear[1] = 1'b1;
    @(negedge mclk);
    chk(event_flags[1], 1'b0);
    src_events.t0_under = 1'b1;
    @(negedge mclk);
    src_events = '0;
    chk(event_flags[1], 1'b1);
    @(negedge mclk);
    chk(event_flags[1], 1'b0);
    event_clear = '0;
    port_c_input_mode = 4'he;
    port_c_pins[0] = 1'b0;
    repeat (6) @(negedge mclk);
    chk(event_flags, 7'h00);
    port_c_pins = 4'hf;
    port_c_input_mode = 4'hf;
    @(negedge mclk);
  endtask

  // All seven pending at once: taken in order, nesting on the stack
  task automatic irq_priority;
    pss_addr_t base;
    base = fetch_address_counter;
    for (int k = 0; k < NUM_IRQ; k++) fire(k, 3);
    repeat (6) @(negedge mclk);
    chk(event_flags, 7'h7f);
    interrupt_enable_flags = '1;
    for (int k = 0; k < NUM_IRQ; k++) begin
      wait_irq();
      chk(irq_index, k[2:0]);
      chk(fetch_address_counter, IRQ_VEC[k]);
      @(negedge mclk);
    end
    interrupt_enable_flags = '0;
    chk(stack_depth, 4'h7);
    for (int k = NUM_IRQ - 2; k >= -1; k--) begin
      do_cmd(PSS_OP_RET, '0, '0, '0);
      chk(fetch_address_counter, (k < 0) ? base : IRQ_VEC[k]);
    end
    chk(stack_depth, 4'h0);
    port_c_pins = 4'hf;
    ext_int_n = 1'b1;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    failures = 0;
    total_checks = 0;
    mclk = 1'b0;
    reset_n = 1'b0;
    cmd = '0;
    interrupt_enable_flags = '0;
    event_clear = '0;
    port_c_input_mode = 4'hf;
    src_events = '0;
    port_c_pins = 4'hf;
    ext_int_n = 1'b1;
    repeat (5) @(negedge mclk);
    chk(fetch_address_counter, 11'h000);
    chk(stack_depth, 4'h0);
    reset_n = 1'b1;
    @(negedge mclk);
    flow_basic();
    stack_overflow();
    table_rd(11'h000, 7'h11);
    table_rd(11'h001, 7'h22);
    table_rd(11'h002, 7'h33);
    table_rd(11'h3fb, 7'h44);
    table_rd(11'h7ff, 7'h7f);
    for (int k = 0; k < NUM_IRQ; k++) begin
      if (k == 2) begin
        for (int p = 0; p < PORTC_W; p++) irq_one(k, p);
      end else begin
        irq_one(k, 0);
      end
    end
    irq_priority();
    flag_clear();
    end_of_test();
  end
endmodule
